// *** hw/csr_pkg.sv ***
// Purpose: Shared constants and types for the clock select and reset control block
// Assumes: 8-bit registers in the low byte of a 32-bit classic Wishbone word
// Notes: Byte address of a register is four times its index
package csr_pkg;
  // Register indices; byte address = index * 4
  localparam logic [5:0] IDX_CMODE = 6'h03;
  localparam logic [5:0] IDX_AUX = 6'h08;
  localparam logic [5:0] IDX_STAT = 6'h10;

  localparam logic [7:0] CMODE_RST = 8'hf6;
  localparam logic [7:0] CMODE_DIV2 = 8'h34;
  localparam logic [7:0] CMODE_DIV4 = 8'h14;
  localparam logic [7:0] CMODE_DIV8 = 8'h3c;
  localparam logic [7:0] CMODE_DIV16 = 8'h1c;
  localparam logic [7:0] CMODE_DIV32 = 8'h7c;
  localparam logic [7:0] CMODE_SLOW = 8'he4;

  localparam int CM_SEL_HI = 7;
  localparam int CM_SEL_LO = 5;
  localparam int CM_FAST_EN = 4;
  localparam int CM_TYPE = 3;
  localparam int CM_SLOW_EN = 2;
  localparam int CM_WDT_EN = 1;
  localparam int CM_PIN_RST = 0;

  localparam logic [7:0] AUX_RST = 8'h00;
  localparam logic [7:0] AUX_MASK = 8'h17;
  localparam int AUX_WDT_HI = 1;
  localparam int AUX_WDT_LO = 0;
  localparam int AUX_LVR_OFF = 2;
  localparam int AUX_BIAS = 4;

  // Status register bits
  localparam int STB_POR = 0;
  localparam int STB_LVR = 1;
  localparam int STB_WDT = 2;
  localparam int STB_PIN = 3;
  localparam int STB_RAM_OK = 4;
  localparam int STB_UNSAFE = 5;
  localparam int STB_TRIMMED = 6;

  localparam logic [3:0] CAUSE_POR = 4'h1;
  localparam logic [3:0] RST_HOLD_CYC = 4'h4;
  localparam logic [7:0] RESTART_VEC = 8'h00;
  // Synchroniser idle levels: {low-voltage detect, external reset pin}
  localparam logic [1:0] SYNC_RST = 2'h1;

  typedef enum logic [2:0] {
    CAL_OFF = 3'h0, CAL_DIV2 = 3'h1, CAL_DIV4 = 3'h2, CAL_DIV8 = 3'h3,
    CAL_DIV16 = 3'h4, CAL_DIV32 = 3'h5, CAL_SLOW = 3'h6
  } csr_cal_t;

  typedef enum logic [1:0] {ST_LOAD = 2'h0, ST_TRIM = 2'h1, ST_RUN = 2'h3} csr_state_t;

  typedef enum logic [1:0] {SRC_FAST = 2'h0, SRC_SLOW = 2'h1, SRC_XTAL = 2'h2, SRC_NONE = 2'h3} csr_src_t;

  typedef struct packed {
    csr_src_t src;
    logic [2:0] div_log2;
  } csr_clk_t;

  // Maps select code and table type to source and divide exponent
  function automatic csr_clk_t csr_decode(input logic [2:0] sel, input logic typ);
    csr_clk_t c;
    c = '{SRC_NONE, 3'h0};
    if (!typ) begin
      case (sel)
        3'h0: c = '{SRC_FAST, 3'h2};
        3'h1: c = '{SRC_FAST, 3'h1};
        3'h3: c = '{SRC_XTAL, 3'h2};
        3'h4: c = '{SRC_XTAL, 3'h1};
        3'h5: c = '{SRC_XTAL, 3'h0};
        3'h6: c = '{SRC_SLOW, 3'h2};
        3'h7: c = '{SRC_SLOW, 3'h0};
        default: c = '{SRC_NONE, 3'h0};
      endcase
    end else begin
      case (sel)
        3'h0: c = '{SRC_FAST, 3'h4};
        3'h1: c = '{SRC_FAST, 3'h3};
        3'h2: c = '{SRC_SLOW, 3'h4};
        3'h3: c = '{SRC_FAST, 3'h5};
        3'h4: c = '{SRC_FAST, 3'h6};
        3'h5: c = '{SRC_XTAL, 3'h3};
        default: c = '{SRC_NONE, 3'h0};
      endcase
    end
    return c;
  endfunction
endpackage

// *** hw/csr_rst_if.sv ***
// Purpose: Carries reset requests to the reset generator and its results back
// Assumes: Requests are level signals on clk_i
// Notes: cause holds {pin, watchdog, low-voltage, power-on}
`timescale 1ns/1ps
interface csr_rst_if;
  logic lvr_req;
  logic wdt_req;
  logic pin_req;
  logic sys_rst;
  logic [3:0] cause;
  modport gen (input lvr_req, wdt_req, pin_req, output sys_rst, cause);
  modport ctl (output lvr_req, wdt_req, pin_req, input sys_rst, cause);
endinterface

// *** hw/csr_reset_gen.sv ***
// Purpose: Merges reset sources into one internal reset and records its cause
// Assumes: rst_i is the power-on reset
// Notes: Reset is held for a fixed count after the last request falls
`timescale 1ns/1ps
module csr_reset_gen
  import csr_pkg::*;
#(
  parameter logic [3:0] HOLD = RST_HOLD_CYC
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Power-on reset, sync, active high
  csr_rst_if.gen rif      // Requests in, reset and cause out
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic next_rst;
  logic [3:0] next_cause;
  logic [3:0] req;

  always_comb begin
    req = {rif.pin_req, rif.wdt_req, rif.lvr_req, 1'b0};
    next_cnt = cnt;
    next_rst = rif.sys_rst;
    next_cause = rif.cause;
    if (|req) begin
      next_cnt = HOLD;
      next_rst = 1'b1;
      next_cause = rif.sys_rst ? (rif.cause | req) : req;
    end else if (cnt != 4'h0) begin
      next_cnt = cnt - 4'h1;
    end else begin
      next_rst = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= HOLD;
      rif.sys_rst <= 1'b1;
      rif.cause <= CAUSE_POR;
    end else begin
      cnt <= next_cnt;
      rif.sys_rst <= next_rst;
      rif.cause <= next_cause;
    end
  end

  a_req_gives_rst: assert property (@(posedge clk_i) disable iff (rst_i)
    (rif.lvr_req || rif.wdt_req || rif.pin_req) |=> rif.sys_rst ##1 rif.sys_rst)
    else $error("reset request did not assert internal reset");
  a_keep_ram_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    (!rif.sys_rst && (rif.wdt_req || rif.pin_req) && !rif.lvr_req) |=> !rif.cause[0] && !rif.cause[1])
    else $error("watchdog or pin reset marked as losing memory");
  a_lvr_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    rif.lvr_req |=> rif.cause[1])
    else $error("low-voltage reset cause not recorded");
endmodule

// *** hw/csr_clock_reset.sv ***
// What this block does
// - Calibrated boot for fast/4 or fast/2 loads 14h or 34h into clock mode.
// - Calibrated boot for fast/8 or fast/16 loads 3Ch or 1Ch into clock mode.
// - Calibrated boot for fast/32 loads 7Ch; slow oscillator option loads E4h.
// - With calibration off, boot leaves clock mode at its reset value.
// - Any calibrated boot: watchdog off, slow oscillator on, port pin as input.
// - Oscillator trimming runs once, only while the programmer writes memory.
// - A write switching source and killing the running oscillator switches source but keeps that oscillator enabled.
// - Power-on, low-voltage, watchdog and pin all reset; execution restarts at 00h.
// - Pin and watchdog resets keep data memory contents.
// - Power-on and low-voltage resets leave data memory undefined.
// - Low-voltage reset acts only after power-on has completed.
// - Auxiliary bit 2 set disables low-voltage reset; reset value enables it.
// - Low-voltage reset is inactive in light or deep sleep.
// - Auxiliary bits 1-0 pick watchdog timeout of 8k, 16k, 64k or 256k.
// - Auxiliary bit 4 enables the half-supply bias; write-only, resets to 0.
// - Clock mode layout: select, fast enable, type, slow enable, watchdog, pin.
// - Select codes per table type; slow oscillator off also stops the watchdog.
//
// Purpose: Clock source selection, boot state loading and reset control
// Assumes: Classic Wishbone slave, 32-bit data, registers in the low byte
// Notes: Straps and trim handshake are on clk_i; reset and detect pins are not
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
module csr_clock_reset
  import csr_pkg::*;
(
  input wire logic clk_i,                      // 250 MHz clock
  input wire logic rst_i,                      // Sync reset, active high, power-on
  input wire logic wb_cyc_i,                   // Bus cycle
  input wire logic wb_stb_i,                   // Bus strobe
  input wire logic wb_we_i,                    // Write enable
  input wire logic [7:0] wb_adr_i,             // Byte address
  input wire logic [3:0] wb_sel_i,             // Byte lane selects
  input wire logic [31:0] wb_dat_i,            // Write data
  output logic [31:0] wb_dat_o,                // Read data
  output logic wb_ack_o,                       // Acknowledge
  input wire csr_pkg::csr_cal_t cal_opt_i,     // Calibration option strap
  input wire logic writer_mode_i,              // Programmer is writing memory
  input wire logic trim_stored_i,              // Trim already stored in memory
  input wire logic trim_done_i,                // Trim routine finished
  input wire logic lvr_detect_i,               // Supply below threshold, async
  input wire logic ext_reset_n_pin_i,          // External reset pin, async, active low
  input wire logic wdt_overflow_i,             // Watchdog counter overflow
  input wire logic light_sleep_i,              // Light-sleep mode
  input wire logic deep_sleep_i,               // Deep-sleep mode
  output csr_pkg::csr_src_t clk_src_o,         // Selected clock source
  output logic [2:0] clk_div_log2_o,           // Divide exponent
  output logic fast_osc_en_o,                  // Fast oscillator enable
  output logic slow_osc_en_o,                  // Slow oscillator enable
  output logic wdt_en_o,                       // Watchdog enable
  output logic [1:0] wdt_period_sel_o,         // Watchdog timeout select
  output logic lvr_en_o,                       // Low-voltage reset active
  output logic bias_en_o,                      // Half-supply bias enable
  output logic port_a_bit5_reset_o,            // Shared pin acts as reset input
  output logic trim_run_o,                     // Run oscillator trimming
  output logic sys_rst_o,                      // Internal system reset
  output logic ram_valid_o,                    // Data memory kept over last reset
  output logic [7:0] restart_addr_o            // Execution restart address
);
  csr_rst_if rif ();

  csr_reset_gen #(.HOLD(RST_HOLD_CYC)) u_rst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rif(rif)
  );

  // Three-stage synchronisers; a change counts once stages two and three agree
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] sync3;
  logic [1:0] filt;
  logic [1:0] pin_raw;
  assign pin_raw = {lvr_detect_i, ext_reset_n_pin_i};

  for (genvar g = 0; g < 2; g++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        sync1[g] <= SYNC_RST[g];
        sync2[g] <= SYNC_RST[g];
        sync3[g] <= SYNC_RST[g];
        filt[g] <= SYNC_RST[g];
      end else begin
        sync1[g] <= pin_raw[g];
        sync2[g] <= sync1[g];
        sync3[g] <= sync2[g];
        if (sync2[g] == sync3[g]) begin
          filt[g] <= sync3[g];
        end
      end
    end
  end

  csr_state_t state;
  csr_state_t next_state;
  logic [7:0] cmode;
  logic [7:0] next_cmode;
  logic [7:0] aux;
  logic [7:0] next_aux;
  logic trimmed;
  logic next_trimmed;
  logic unsafe;
  logic next_unsafe;
  logic por_done;
  logic next_por_done;
  logic next_ack;
  logic [31:0] next_rdat;
  logic bus_req;
  logic wr;
  logic [5:0] idx;
  logic [7:0] wval;
  csr_clk_t cur;
  csr_clk_t nclk;
  csr_clk_t oclk;
  logic sleeping;

  assign sleeping = light_sleep_i | deep_sleep_i;
  assign rif.lvr_req = filt[1] & ~aux[AUX_LVR_OFF] & ~sleeping & por_done;
  assign rif.wdt_req = wdt_overflow_i & wdt_en_o;
  assign rif.pin_req = ~filt[0] & cmode[CM_PIN_RST];

  always_comb begin
    next_state = state;
    next_cmode = cmode;
    next_aux = aux;
    next_trimmed = trimmed;
    next_unsafe = unsafe;
    next_por_done = por_done;
    next_ack = 1'b0;
    next_rdat = 32'h0;
    bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // Writes land at the edge where the master sees ack, while it still holds the request
    wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
    idx = wb_adr_i[7:2];
    wval = wb_dat_i[7:0];
    cur = csr_decode(cmode[CM_SEL_HI:CM_SEL_LO], cmode[CM_TYPE]);
    nclk = csr_decode(wval[CM_SEL_HI:CM_SEL_LO], wval[CM_TYPE]);
    case (state)
      ST_LOAD: begin
        case (cal_opt_i)
          CAL_DIV2: next_cmode = CMODE_DIV2;
          CAL_DIV4: next_cmode = CMODE_DIV4;
          CAL_DIV8: next_cmode = CMODE_DIV8;
          CAL_DIV16: next_cmode = CMODE_DIV16;
          CAL_DIV32: next_cmode = CMODE_DIV32;
          CAL_SLOW: next_cmode = CMODE_SLOW;
          default: next_cmode = cmode;
        endcase
        if (cal_opt_i != CAL_OFF && writer_mode_i && !trim_stored_i && !trimmed) begin
          next_state = ST_TRIM;
        end else begin
          next_state = ST_RUN;
        end
      end
      ST_TRIM: begin
        if (trim_done_i) begin
          next_trimmed = 1'b1;
          next_state = ST_RUN;
        end
      end
      default: begin
        next_por_done = 1'b1;
        if (wr && idx == IDX_CMODE) begin
          // Keep the running oscillator alive when a write would also move off it
          if (nclk.src != cur.src && cur.src == SRC_FAST && !wval[CM_FAST_EN]) begin
            wval[CM_FAST_EN] = 1'b1;
          end
          if (nclk.src != cur.src && cur.src == SRC_SLOW && !wval[CM_SLOW_EN]) begin
            wval[CM_SLOW_EN] = 1'b1;
          end
          next_cmode = wval;
        end
      end
    endcase
    if (wr && idx == IDX_AUX) begin
      next_aux = wb_dat_i[7:0] & AUX_MASK;
    end
    if (wr && idx == IDX_STAT && wb_dat_i[STB_UNSAFE]) begin
      next_unsafe = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (state == ST_RUN && wr && idx == IDX_CMODE && wval != wb_dat_i[7:0]) begin
      next_unsafe = 1'b1;
    end
    if (bus_req) begin
      next_ack = 1'b1;
      if (idx == IDX_CMODE) begin
        next_rdat = {24'h0, cmode};
      end else if (idx == IDX_STAT) begin
        next_rdat = {25'h0, trimmed, unsafe, ram_valid_o, rif.cause};
      end else begin
        next_rdat = 32'h0;
      end
    end
    if (rif.sys_rst) begin
      next_state = ST_LOAD;
      next_cmode = CMODE_RST;
      next_aux = AUX_RST;
      next_unsafe = 1'b0;
    end
    oclk = csr_decode(next_cmode[CM_SEL_HI:CM_SEL_LO], next_cmode[CM_TYPE]);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_LOAD;
      cmode <= CMODE_RST;
      aux <= AUX_RST;
      trimmed <= 1'b0;
      unsafe <= 1'b0;
      por_done <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      clk_src_o <= SRC_SLOW;
      clk_div_log2_o <= 3'h0;
      fast_osc_en_o <= CMODE_RST[CM_FAST_EN];
      slow_osc_en_o <= CMODE_RST[CM_SLOW_EN];
      wdt_en_o <= 1'b0;
      wdt_period_sel_o <= AUX_RST[AUX_WDT_HI:AUX_WDT_LO];
      lvr_en_o <= 1'b0;
      bias_en_o <= 1'b0;
      port_a_bit5_reset_o <= 1'b0;
      trim_run_o <= 1'b0;
      sys_rst_o <= 1'b1;
      ram_valid_o <= 1'b0;
      restart_addr_o <= RESTART_VEC;
    end else begin
      state <= next_state;
      cmode <= next_cmode;
      aux <= next_aux;
      trimmed <= next_trimmed;
      unsafe <= next_unsafe;
      por_done <= next_por_done;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_rdat;
      clk_src_o <= oclk.src;
      clk_div_log2_o <= oclk.div_log2;
      fast_osc_en_o <= next_cmode[CM_FAST_EN];
      slow_osc_en_o <= next_cmode[CM_SLOW_EN];
      wdt_en_o <= next_cmode[CM_WDT_EN] & next_cmode[CM_SLOW_EN];
      wdt_period_sel_o <= next_aux[AUX_WDT_HI:AUX_WDT_LO];
      lvr_en_o <= ~next_aux[AUX_LVR_OFF] & ~sleeping & next_por_done;
      bias_en_o <= next_aux[AUX_BIAS];
      port_a_bit5_reset_o <= next_cmode[CM_PIN_RST];
      trim_run_o <= (next_state == ST_TRIM);
      sys_rst_o <= rif.sys_rst;
      ram_valid_o <= ~(rif.cause[STB_POR] | rif.cause[STB_LVR]);
      restart_addr_o <= RESTART_VEC;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_boot_fast_div: assert property (state == ST_LOAD && !rif.sys_rst && cal_opt_i == CAL_DIV4
    |=> cmode == 8'h14 && fast_osc_en_o)
    else $error("divide-by-4 boot value wrong");
  a_boot_div_eight: assert property (state == ST_LOAD && !rif.sys_rst && cal_opt_i == CAL_DIV8
    |=> cmode == 8'h3c && clk_div_log2_o == 3'h3)
    else $error("divide-by-8 boot value wrong");
  a_boot_slow_osc: assert property (state == ST_LOAD && !rif.sys_rst && cal_opt_i == CAL_SLOW
    |=> cmode == 8'he4 && !fast_osc_en_o && clk_src_o == SRC_SLOW)
    else $error("slow oscillator boot value wrong");
  a_boot_no_cal: assert property (state == ST_LOAD && !rif.sys_rst && cal_opt_i == CAL_OFF
    |=> cmode == $past(cmode) && !trim_run_o)
    else $error("boot changed clock mode with calibration off");
  a_boot_cal_state: assert property (state == ST_LOAD && !rif.sys_rst && cal_opt_i != CAL_OFF
    |=> !wdt_en_o && slow_osc_en_o && !port_a_bit5_reset_o)
    else $error("calibrated boot left watchdog or pin function wrong");
  a_trim_once: assert property ($rose(trim_run_o) |-> !trimmed && !trim_stored_i)
    else $error("trimming started a second time");
  a_unsafe_kept: assert property (state == ST_RUN && !rif.sys_rst && wr && idx == IDX_CMODE
    && cur.src == SRC_FAST && nclk.src != SRC_FAST |=> fast_osc_en_o)
    else $error("running fast oscillator was switched off");
  a_lvr_sleep_off: assert property (sleeping |-> !rif.lvr_req ##1 !lvr_en_o)
    else $error("low-voltage reset active during sleep");
  a_lvr_disable: assert property (aux[AUX_LVR_OFF] |-> !rif.lvr_req && !lvr_en_o)
    else $error("low-voltage reset active while disabled");
  a_wdt_slow_off: assert property (!cmode[CM_SLOW_EN] |-> !wdt_en_o)
    else $error("watchdog enabled without slow oscillator");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held longer than one cycle");
  a_rst_release: assert property ($fell(rif.sys_rst) |-> state == ST_LOAD ##1 !sys_rst_o)
    else $error("internal reset released out of step");
  a_slow_kept: assert property (state == ST_RUN && !rif.sys_rst && wr && idx == IDX_CMODE
    && cur.src == SRC_SLOW && nclk.src != SRC_SLOW |=> slow_osc_en_o)
    else $error("running slow oscillator was switched off");
  a_lvr_after_por: assert property (!por_done |-> !rif.lvr_req && !lvr_en_o)
    else $error("low-voltage reset active before power-on completed");
endmodule

// *** sim/csr_clock_reset_test.sv ***
// Purpose: Self-checking bench for the clock select and reset control block
// Assumes: Each bus request is answered by a one-cycle ack; only the watchdog ends a bus wait, reset waits give up after 100 or 20 cycles
// Notes: Boot and aux cases run from tables, with unsafe writes between them; resets and trimming follow
`timescale 1ns/1ps
module csr_clock_reset_test;
  import csr_pkg::*;
  `define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
  logic clk_i = 1'b0;
  logic rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic writer_mode_i = 1'b0, trim_stored_i = 1'b0, trim_done_i = 1'b0, lvr_detect_i = 1'b0;
  logic ext_reset_n_pin_i = 1'b1, wdt_overflow_i = 1'b0, light_sleep_i = 1'b0, deep_sleep_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  csr_cal_t cal_opt_i = CAL_OFF;
  csr_src_t clk_src_o;
  logic wb_ack_o, fast_osc_en_o, slow_osc_en_o, wdt_en_o, lvr_en_o, bias_en_o, port_a_bit5_reset_o;
  logic trim_run_o, sys_rst_o, ram_valid_o;
  logic [1:0] wdt_period_sel_o;
  logic [2:0] clk_div_log2_o;
  logic [7:0] restart_addr_o, rd;
  int fail_count = 0;
  int check_count = 0;
  typedef struct {csr_cal_t cal; logic [7:0] cm; csr_src_t src; logic [2:0] dv; logic wd;} csr_boot_t;
  typedef struct {logic [7:0] d; logic [1:0] per; logic lv; logic bi;} csr_auxrow_t;
  csr_boot_t boot_rows [7] = '{'{CAL_OFF, 8'hf6, SRC_SLOW, 3'h0, 1'b1}, '{CAL_DIV2, 8'h34, SRC_FAST, 3'h1, 1'b0},
    '{CAL_DIV4, 8'h14, SRC_FAST, 3'h2, 1'b0}, '{CAL_DIV8, 8'h3c, SRC_FAST, 3'h3, 1'b0},
    '{CAL_DIV16, 8'h1c, SRC_FAST, 3'h4, 1'b0}, '{CAL_DIV32, 8'h7c, SRC_FAST, 3'h5, 1'b0},
    '{CAL_SLOW, 8'he4, SRC_SLOW, 3'h0, 1'b0}};
  csr_auxrow_t aux_rows [5] = '{'{8'h00, 2'h0, 1'b1, 1'b0}, '{8'h06, 2'h2, 1'b0, 1'b0},
    '{8'h13, 2'h3, 1'b1, 1'b1}, '{8'h17, 2'h3, 1'b0, 1'b1}, '{8'h01, 2'h1, 1'b1, 1'b0}};

  always #2 clk_i = ~clk_i;

  csr_clock_reset i_csr_clock_reset (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cal_opt_i(cal_opt_i), .writer_mode_i(writer_mode_i), .trim_stored_i(trim_stored_i),
    .trim_done_i(trim_done_i), .lvr_detect_i(lvr_detect_i), .ext_reset_n_pin_i(ext_reset_n_pin_i),
    .wdt_overflow_i(wdt_overflow_i), .light_sleep_i(light_sleep_i), .deep_sleep_i(deep_sleep_i),
    .clk_src_o(clk_src_o), .clk_div_log2_o(clk_div_log2_o), .fast_osc_en_o(fast_osc_en_o),
    .slow_osc_en_o(slow_osc_en_o), .wdt_en_o(wdt_en_o), .wdt_period_sel_o(wdt_period_sel_o),
    .lvr_en_o(lvr_en_o), .bias_en_o(bias_en_o), .port_a_bit5_reset_o(port_a_bit5_reset_o),
    .trim_run_o(trim_run_o), .sys_rst_o(sys_rst_o), .ram_valid_o(ram_valid_o), .restart_addr_o(restart_addr_o)
  );

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Called just after a rising edge; request held until ack is sampled high
  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
    `CHK("ack dropped", 1'b0, wb_ack_o)
  endtask

  task automatic wait_boot();
    int n;
    n = 0;
    while (sys_rst_o !== 1'b0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("reset released", 1'b0, sys_rst_o)
    repeat (3) @(posedge clk_i);
  endtask

  task automatic wait_rst();
    int n;
    n = 0;
    while (sys_rst_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("reset raised", 1'b1, sys_rst_o)
    wait_boot();
  endtask

  task automatic do_reset(input int n);
    rst_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_boot();
  endtask

  task automatic pin_pulse();
    ext_reset_n_pin_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    ext_reset_n_pin_i <= 1'b1;
    wait_rst();
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    `CHK("reset held", 1'b1, sys_rst_o)
    `CHK("lvr before power-on", 1'b0, lvr_en_o)
    `CHK("ack idle", 1'b0, wb_ack_o)
    rst_i <= 1'b0;
    wait_boot();
    foreach (boot_rows[i]) begin
      cal_opt_i <= boot_rows[i].cal;
      do_reset(3);
      bus(1'b0, 8'h0c, 8'h00);
      `CHK("boot clock mode", boot_rows[i].cm, rd)
      `CHK("clock source", boot_rows[i].src, clk_src_o)
      `CHK("divide", boot_rows[i].dv, clk_div_log2_o)
      `CHK("watchdog enable", boot_rows[i].wd, wdt_en_o)
      `CHK("slow osc enable", 1'b1, slow_osc_en_o)
      `CHK("fast osc enable", boot_rows[i].cm[4], fast_osc_en_o)
      `CHK("pin as port", 1'b0, port_a_bit5_reset_o)
      `CHK("restart address", 8'h00, restart_addr_o)
    end
    bus(1'b1, 8'h0c, 8'hf4);
    `CHK("fast osc enabled first", 1'b1, fast_osc_en_o)
    `CHK("still on slow", SRC_SLOW, clk_src_o)
    // Running from slow: select fast/4 and stop slow in one write
    bus(1'b1, 8'h0c, 8'h10);
    bus(1'b0, 8'h0c, 8'h00);
    `CHK("unsafe write kept slow", 8'h14, rd)
    bus(1'b0, 8'h40, 8'h00);
    `CHK("unsafe flag", 1'b1, rd[5])
    bus(1'b1, 8'h40, 8'h20);
    bus(1'b1, 8'h0c, 8'h12);
    bus(1'b0, 8'h0c, 8'h00);
    `CHK("later slow disable", 8'h12, rd)
    `CHK("slow osc off", 1'b0, slow_osc_en_o)
    `CHK("watchdog follows slow osc", 1'b0, wdt_en_o)
    bus(1'b1, 8'h0c, 8'h16);
    `CHK("watchdog back on", 1'b1, wdt_en_o)
    bus(1'b0, 8'h40, 8'h00);
    `CHK("unsafe flag clear", 1'b0, rd[5])
    // Running from fast: select slow and stop fast in one write
    bus(1'b1, 8'h0c, 8'he6);
    bus(1'b0, 8'h0c, 8'h00);
    `CHK("unsafe write kept fast", 8'hf6, rd)
    `CHK("fast osc kept", 1'b1, fast_osc_en_o)
    `CHK("moved to slow", SRC_SLOW, clk_src_o)
    bus(1'b0, 8'h40, 8'h00);
    `CHK("unsafe flag from fast", 1'b1, rd[5])
    foreach (aux_rows[i]) begin
      bus(1'b1, 8'h20, aux_rows[i].d);
      repeat (2) @(posedge clk_i);
      `CHK("watchdog period", aux_rows[i].per, wdt_period_sel_o)
      `CHK("lvr enable", aux_rows[i].lv, lvr_en_o)
      `CHK("bias enable", aux_rows[i].bi, bias_en_o)
      bus(1'b0, 8'h20, 8'h00);
      `CHK("aux write-only", 8'h00, rd)
    end
    light_sleep_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK("lvr off in light sleep", 1'b0, lvr_en_o)
    light_sleep_i <= 1'b0;
    deep_sleep_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK("lvr off in deep sleep", 1'b0, lvr_en_o)
    deep_sleep_i <= 1'b0;
    bus(1'b0, 8'h04, 8'h00);
    `CHK("unmapped read", 8'h00, rd)
    cal_opt_i <= CAL_OFF;
    do_reset(3);
    wdt_overflow_i <= 1'b1;
    @(posedge clk_i);
    wdt_overflow_i <= 1'b0;
    wait_rst();
    `CHK("ram kept after watchdog", 1'b1, ram_valid_o)
    bus(1'b0, 8'h40, 8'h00);
    `CHK("watchdog cause", 4'h4, rd[3:0])
    bus(1'b1, 8'h0c, 8'hf7);
    `CHK("pin as reset", 1'b1, port_a_bit5_reset_o)
    pin_pulse();
    `CHK("ram kept after pin", 1'b1, ram_valid_o)
    bus(1'b0, 8'h40, 8'h00);
    `CHK("pin cause", 4'h8, rd[3:0])
    lvr_detect_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    lvr_detect_i <= 1'b0;
    wait_rst();
    `CHK("ram lost after low voltage", 1'b0, ram_valid_o)
    bus(1'b0, 8'h40, 8'h00);
    `CHK("low voltage cause", 4'h2, rd[3:0])
    bus(1'b1, 8'h20, 8'h04);
    lvr_detect_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    `CHK("lvr disabled", 1'b0, sys_rst_o)
    lvr_detect_i <= 1'b0;
    cal_opt_i <= CAL_DIV4;
    writer_mode_i <= 1'b1;
    do_reset(3);
    `CHK("trim running", 1'b1, trim_run_o)
    trim_done_i <= 1'b1;
    @(posedge clk_i);
    trim_done_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK("trim ended", 1'b0, trim_run_o)
    bus(1'b0, 8'h0c, 8'h00);
    `CHK("boot after trim", 8'h14, rd)
    bus(1'b1, 8'h0c, 8'h15);
    pin_pulse();
    `CHK("no second trim", 1'b0, trim_run_o)
    bus(1'b0, 8'h40, 8'h00);
    `CHK("trimmed flag", 1'b1, rd[6])
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    close_out();
  end
endmodule
